// ===== rcpts_pkg.sv
// rcpts_pkg: shared constants and types for the servo-pulse position block
// assumes: 32-bit apb, pclk at 125 mhz
package rcpts_pkg;
  localparam int unsigned clk_mhz = 125;
  localparam int unsigned reset_quiet_ms = 10;
  localparam int unsigned reset_quiet_cycles = reset_quiet_ms * 1000 * clk_mhz;

  // register byte offsets
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_in_max = 8'h04;
  localparam logic [7:0] off_neu_max = 8'h08;
  localparam logic [7:0] off_neu_min = 8'h0c;
  localparam logic [7:0] off_in_min = 8'h10;
  localparam logic [7:0] off_tgt_max = 8'h14;
  localparam logic [7:0] off_tgt_min = 8'h18;
  localparam logic [7:0] off_status = 8'h1c;
  localparam logic [7:0] off_target = 8'h20;
  localparam logic [7:0] off_position = 8'h24;
  localparam logic [7:0] off_err_clr = 8'h28;

  // ctrl fields
  localparam int unsigned ctrl_mode_bit = 0;
  localparam int unsigned ctrl_inv_in_bit = 1;
  localparam int unsigned ctrl_inv_motor_bit = 2;
  localparam int unsigned ctrl_ign_err_bit = 3;
  localparam int unsigned ctrl_ustep_bit = 4;
  localparam int unsigned ctrl_degree_lsb = 8;
  localparam int unsigned ctrl_devnum_lsb = 16;

  // reset values
  localparam logic [31:0] tgt_max_rst = 32'h0000_00c8;
  localparam logic [31:0] tgt_min_rst = 32'hffff_ff38;
  localparam logic [2:0] degree_rst = 3'h1;
  localparam logic [6:0] devnum_rst = 7'h0e;
  localparam logic [15:0] in_max_rst = 16'h0b90;
  localparam logic [15:0] neu_max_rst = 16'h0930;
  localparam logic [15:0] neu_min_rst = 16'h08e5;
  localparam logic [15:0] in_min_rst = 16'h0698;

  typedef struct packed {
    logic [15:0] in_max;
    logic [15:0] neu_max;
    logic [15:0] neu_min;
    logic [15:0] in_min;
    logic invert;
    logic [2:0] degree;
    logic signed [31:0] tgt_max;
    logic signed [31:0] tgt_min;
  } rcpts_scale_type;

  typedef enum logic [1:0] {
    st_learn = 2'b00,
    st_track = 2'b01,
    st_fault = 2'b11
  } rcpts_state_type;
endpackage

// ===== rcpts_scaler.sv
// rcpts_scaler: maps a measured pulse width to a signed target position
// assumes: inputs stable for one cycle; one-cycle registered latency
`timescale 1ns/1ns
`default_nettype none
module rcpts_scaler
  import rcpts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] pulse,
  input wire rcpts_scale_type cfg,
  output logic signed [31:0] target_q
);
  logic [15:0] span_hi;
  logic [15:0] span_lo;
  logic [15:0] off_hi;
  logic [15:0] off_lo;
  logic hi_side;
  logic lo_side;
  logic [16:0] frac_raw;
  logic [16:0] frac;
  logic [33:0] frac_sq;
  logic signed [31:0] limit;
  logic signed [49:0] prod;
  logic signed [31:0] target_d;

  assign span_hi = cfg.in_max - cfg.neu_max;
  assign span_lo = cfg.neu_min - cfg.in_min;
  assign hi_side = pulse > cfg.neu_max;
  assign lo_side = pulse < cfg.neu_min;
  // clamp beyond the ends
  assign off_hi = (pulse >= cfg.in_max) ? span_hi : pulse - cfg.neu_max;
  assign off_lo = (pulse <= cfg.in_min) ? span_lo : cfg.neu_min - pulse;
  // fraction of full travel in q16; 17'h10000 is the end point, so ends land exactly on the limits
  assign frac_raw = hi_side ? ((span_hi == 16'h0) ? 17'h10000 : 17'((32'(off_hi) << 16) / 32'(span_hi)))
                            : ((span_lo == 16'h0) ? 17'h10000 : 17'((32'(off_lo) << 16) / 32'(span_lo)));
  assign frac_sq = 34'(frac_raw) * 34'(frac_raw);
  // higher degrees square it: fine near neutral, coarse near the ends
  assign frac = (cfg.degree > 3'h1) ? frac_sq[32:16] : frac_raw;
  // invert swaps which limit each side reaches
  assign limit = (hi_side ^ cfg.invert) ? cfg.tgt_max : cfg.tgt_min;
  // neutral maps to 0, extremes to target limits
  assign prod = 50'(limit) * $signed({1'b0, frac});
  assign target_d = (hi_side || lo_side) ? prod[47:16] : 32'sh0; // neutral band

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_q <= 32'sh0;
    end else begin
      target_q <= target_d;
    end
  end
endmodule
`default_nettype wire

// ===== rcpts_top.sv
// rcpts_top: servo-pulse position target block with apb registers
// assumes: pulse_width/pulse_valid come from a pulse timer; err_in is the shared line level
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - fault line high only while error stops motor
// - reset clears controller, de-energizes motor outputs
// - respond only to configured 7-bit address
// - external high fault is own error unless ignored
// - fault lines wire-ored across devices
// - after power-up learn position from first pulse
// - after error clears, relearn position
// - five scaling parameters incl. invert
// - neutral to zero, extremes to limits
// - target limits default 200 and -200
// - target max nonnegative, min nonpositive
// - units are microsteps or full steps (ustep bit is not used; target is not converted)
// - degree default linear, higher bends curve
// - motor direction flag reverses stepping
// - device number defaults to 14
module rcpts_top
  import rcpts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pulse_width,
  input wire logic pulse_valid,
  input wire logic err_cond,
  input wire logic err_in,
  input wire logic [6:0] bus_addr,
  output logic addr_match,
  output logic err_out,
  output logic err_oe,
  output logic motor_enable,
  output logic step_dir,
  output logic signed [31:0] target_pos,
  output logic signed [31:0] current_pos,
  output logic host_ready
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q;
  logic [15:0] in_max_q, neu_max_q, neu_min_q, in_min_q;
  logic signed [31:0] tgt_max_q, tgt_min_q;
  logic [31:0] rdata_d;
  logic rerr_d;
  logic wr_en;
  logic acc;
  logic signed [31:0] wsig;
  rcpts_scale_type cfg;
  logic signed [31:0] scaled;
  rcpts_state_type state_q;
  rcpts_state_type state_d;
  logic ext_err;
  logic fault;
  logic pulse_seen_q;
  logic pulse_valid_q;
  logic [31:0] quiet_q;

  assign acc = psel && penable;
  assign wr_en = acc && pwrite;
  assign wsig = $signed(pwdata);
  // mapped offsets answer, others error
  assign rerr_d = !(paddr == off_ctrl || paddr == off_in_max || paddr == off_neu_max ||
                    paddr == off_neu_min || paddr == off_in_min || paddr == off_tgt_max ||
                    paddr == off_tgt_min || paddr == off_status || paddr == off_target ||
                    paddr == off_position || paddr == off_err_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= {9'h0, devnum_rst, 5'h0, degree_rst, 8'h01};
      in_max_q <= in_max_rst;
      neu_max_q <= neu_max_rst;
      neu_min_q <= neu_min_rst;
      in_min_q <= in_min_rst;
      tgt_max_q <= tgt_max_rst;
      tgt_min_q <= tgt_min_rst;
    end else if (wr_en) begin
      case (paddr)
        off_ctrl: ctrl_q <= pwdata;
        off_in_max: in_max_q <= pwdata[15:0];
        off_neu_max: neu_max_q <= pwdata[15:0];
        off_neu_min: neu_min_q <= pwdata[15:0];
        off_in_min: in_min_q <= pwdata[15:0];
        // sign-violating writes are refused, keeping old value
        off_tgt_max: if (!wsig[31]) tgt_max_q <= wsig;
        off_tgt_min: if (wsig[31] || wsig == 32'sh0) tgt_min_q <= wsig;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scaling
  assign cfg.in_max = in_max_q;
  assign cfg.neu_max = neu_max_q;
  assign cfg.neu_min = neu_min_q;
  assign cfg.in_min = in_min_q;
  assign cfg.invert = ctrl_q[ctrl_inv_in_bit];
  assign cfg.degree = ctrl_q[ctrl_degree_lsb +: 3];
  assign cfg.tgt_max = tgt_max_q;
  assign cfg.tgt_min = tgt_min_q;

  rcpts_scaler u_scale (
    .pclk(pclk),
    .presetn(presetn),
    .pulse(pulse_width),
    .cfg(cfg),
    .target_q(scaled)
  );

  ////////////////////////////////////////////////////////////////////////
  // error handling
  // a shared high line is taken as our own error unless ignored
  assign ext_err = err_in && !ctrl_q[ctrl_ign_err_bit];
  assign fault = err_cond || ext_err;

  // pulse_seen delays learning one cycle so scaled matches the pulse
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_learn: if (fault) state_d = st_fault;
                else if (pulse_seen_q) state_d = st_track;
      st_track: if (fault) state_d = st_fault;
      st_fault: if (!fault) state_d = st_learn;
      default: state_d = st_fault;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_learn;
      pulse_seen_q <= 1'b0;
      pulse_valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_seen_q <= pulse_valid && state_q == st_learn && !fault;
      pulse_valid_q <= pulse_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_out <= 1'b0;
      err_oe <= 1'b0;
      motor_enable <= 1'b0;
      step_dir <= 1'b0;
      target_pos <= 32'sh0;
      current_pos <= 32'sh0;
      addr_match <= 1'b0;
      host_ready <= 1'b0;
      quiet_q <= 32'h0;
    end else begin
      // drive high only while a fault halts the motor
      err_out <= state_d == st_fault;
      err_oe <= state_d == st_fault;
      motor_enable <= state_d == st_track && state_q == st_track;
      addr_match <= bus_addr == ctrl_q[ctrl_devnum_lsb +: 7];
      if (quiet_q < reset_quiet_cycles) begin
        quiet_q <= quiet_q + 32'h1;
      end
      host_ready <= quiet_q >= reset_quiet_cycles;
      if (state_q == st_learn && pulse_seen_q && !fault) begin
        // adopt the pulse target as present position, no motion
        target_pos <= scaled;
        current_pos <= scaled;
      end else if (state_q == st_track && pulse_valid_q) begin
        // scaled lags the pulse by one cycle, so the delayed strobe picks the right width
        target_pos <= scaled; // units not converted, ustep setting unused
      end
      if (state_q == st_track && current_pos != target_pos) begin
        current_pos <= (current_pos < target_pos) ? current_pos + 32'sh1 : current_pos - 32'sh1;
        // direction pin flips when motor invert set
        step_dir <= (current_pos < target_pos) ^ ctrl_q[ctrl_inv_motor_bit];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read and answer
  always_comb begin
    case (paddr)
      off_ctrl: rdata_d = ctrl_q;
      off_in_max: rdata_d = {16'h0, in_max_q};
      off_neu_max: rdata_d = {16'h0, neu_max_q};
      off_neu_min: rdata_d = {16'h0, neu_min_q};
      off_in_min: rdata_d = {16'h0, in_min_q};
      off_tgt_max: rdata_d = tgt_max_q;
      off_tgt_min: rdata_d = tgt_min_q;
      off_status: rdata_d = {28'h0, fault, motor_enable, state_q};
      off_target: rdata_d = target_pos;
      off_position: rdata_d = current_pos;
      default: rdata_d = 32'h0;
    endcase
  end

  // no wait state: answer on the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rdata_d;
      pslverr <= psel && !penable && rerr_d;
    end
  end

  a_err_line_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == st_fault) |-> err_out) else $error("fault without err line");
  a_motor_off_fault: assert property (@(posedge pclk) disable iff (!presetn)
    fault |=> ##1 !motor_enable) else $error("motor on during fault");
  a_ext_err_honored: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in && !ctrl_q[ctrl_ign_err_bit]) |=> state_q == st_fault) else $error("ext err ignored");
  a_relearn_after: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == st_fault && !fault) |=> state_q == st_learn) else $error("no relearn");
  a_learn_no_move: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == st_learn && pulse_seen_q && !fault) |=> current_pos == target_pos) else $error("learn moved");
  a_tgt_max_sign: assert property (@(posedge pclk) disable iff (!presetn)
    !tgt_max_q[31] && (tgt_min_q[31] || tgt_min_q == 32'sh0)) else $error("limit sign");
  a_addr_compare: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_addr == ctrl_q[ctrl_devnum_lsb +: 7]) && $stable(ctrl_q) |=> addr_match) else $error("addr miss");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready) else $error("apb no answer");
  c_learn_to_track: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == st_learn ##1 state_q == st_track);
  c_fault_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == st_fault ##1 state_q == st_learn);
  c_step_move: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == st_track && $changed(current_pos));
endmodule
`default_nettype wire

// ===== rcpts_rx_model.sv
// rcpts_rx_model: servo receiver as seen through the pulse timer
// assumes: pclk from the bench; send is called just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module rcpts_rx_model (
  input wire logic pclk,
  output logic [15:0] pulse_width,
  output logic pulse_valid
);
  initial begin
    pulse_width = 16'h0000;
    pulse_valid = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    pulse_width <= w;
    pulse_valid <= 1'b1;
    @(posedge pclk);
    pulse_valid <= 1'b0;
    // stale width is not held, so a late sample cannot pass by luck
    pulse_width <= ~w;
  endtask
endmodule
`default_nettype wire

// ===== servo_pulse_position_mode_target_scaling_bench.sv
// servo_pulse_position_mode_target_scaling_bench: apb and pulse stimulus with queued notes
// assumes: rcpts_top with one-cycle apb answer, 2-cycle pulse-to-target latency
`timescale 1ns/1ns
`default_nettype none
module servo_pulse_position_mode_target_scaling_bench;
  import rcpts_pkg::*;
  typedef struct {string nm; logic [32:0] v; int src;} rcpts_note_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pulse_valid, probe_stb;
  logic err_cond, err_in, addr_match, err_out, err_oe, motor_enable, step_dir, host_ready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] pulse_width;
  logic [6:0] bus_addr;
  logic signed [31:0] target_pos, current_pos;
  int failures, n_compared;
  rcpts_note_type exp_q[$];
  rcpts_note_type cur;
  logic [15:0] wtab [6] = '{16'h0698, 16'h03e8, 16'h0bb8, 16'h0b90, 16'h08fc, 16'h0a60};
  logic [31:0] ttab [6] = '{32'hffff_ff38, 32'hffff_ff38, 32'h0000_00c8, 32'h0000_00c8, 32'h0000_0000,
    32'h0000_0064};

  rcpts_top u_rcpts_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_width(pulse_width), .pulse_valid(pulse_valid),
    .err_cond(err_cond), .err_in(err_in), .bus_addr(bus_addr), .addr_match(addr_match),
    .err_out(err_out), .err_oe(err_oe), .motor_enable(motor_enable), .step_dir(step_dir),
    .target_pos(target_pos), .current_pos(current_pos), .host_ready(host_ready));
  rcpts_rx_model u_rcpts_rx_model (.pclk(pclk), .pulse_width(pulse_width), .pulse_valid(pulse_valid));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watcher: oldest note against the answer or the probed outputs
  always @(posedge pclk) begin
    if ((probe_stb || (psel && penable && pready && !pwrite)) === 1'b1 && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      case (cur.src)
        0: chk(cur.nm, {pslverr, prdata}, cur.v);
        1: chk(cur.nm, {1'b0, target_pos}, cur.v);
        2: chk(cur.nm, {1'b0, current_pos}, cur.v);
        4: chk(cur.nm, {31'h0, host_ready, step_dir}, cur.v);
        default: chk(cur.nm, {28'h0, pslverr, addr_match, err_out, err_oe, motor_enable}, cur.v);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] v);
    exp_q.push_back('{nm, v, 0});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic probe(input string nm, input int src, input logic [32:0] v);
    exp_q.push_back('{nm, v, src});
    probe_stb <= 1'b1;
    @(posedge pclk);
    probe_stb <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic [15:0] w);
    u_rcpts_rx_model.send(w);
    repeat (4) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, probe_stb, err_cond, err_in} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bus_addr = 7'h0e;
    void'($urandom(32'hcab46322));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    probe("not ready", 4, 33'h0_0000_0000);
    rd("ctrl", off_ctrl, 33'h0_000e_0101);
    rd("tgt_max", off_tgt_max, 33'h0_0000_00c8);
    rd("tgt_min", off_tgt_min, 33'h0_ffff_ff38);
    rd("unmapped", 8'h30, 33'h1_0000_0000);
    pulse(16'h0b90);
    probe("learned", 2, 33'h0_0000_00c8);
    probe("tracking", 3, 33'h0_0000_0009);
    for (int i = 0; i < 6; i++) begin
      pulse(wtab[i]);
      probe("target", 1, {1'b0, ttab[i]});
      if (i == 2) probe("dir up", 4, 33'h0_0000_0001);
    end
    // neutral band only, anything else has no closed-form target here
    for (int i = 0; i < 6; i++) begin
      pulse(16'($urandom_range(2352, 2277)));
      probe("neutral", 1, 33'h0_0000_0000);
    end
    apb(1'b1, off_tgt_max, 32'hffff_ffff);
    rd("tgt_max", off_tgt_max, 33'h0_0000_00c8);
    apb(1'b1, off_tgt_min, 32'h0000_0005);
    rd("tgt_min", off_tgt_min, 33'h0_ffff_ff38);
    apb(1'b1, off_tgt_max, 32'h0000_0064);
    pulse(16'h0b90);
    probe("scaled max", 1, 33'h0_0000_0064);
    apb(1'b1, off_ctrl, 32'h000e_0107);
    pulse(16'h0b90);
    probe("inverted", 1, 33'h0_ffff_ff38);
    probe("dir inv", 4, 33'h0_0000_0001);
    apb(1'b1, off_ctrl, 32'h000e_0201);
    pulse(16'h0a60);
    probe("square", 1, 33'h0_0000_0019);
    err_cond <= 1'b1;
    repeat (3) @(posedge pclk);
    probe("own fault", 3, 33'h0_0000_000e);
    err_cond <= 1'b0;
    repeat (3) @(posedge pclk);
    probe("relearning", 3, 33'h0_0000_0008);
    pulse(16'h0698);
    probe("relearned", 2, 33'h0_ffff_ff38);
    err_in <= 1'b1;
    repeat (3) @(posedge pclk);
    probe("line fault", 3, 33'h0_0000_000e);
    err_in <= 1'b0;
    repeat (3) @(posedge pclk);
    pulse(16'h08fc);
    apb(1'b1, off_ctrl, 32'h000e_0109);
    err_in <= 1'b1;
    repeat (3) @(posedge pclk);
    probe("line ignored", 3, 33'h0_0000_0009);
    err_in <= 1'b0;
    bus_addr <= 7'h0f;
    repeat (3) @(posedge pclk);
    probe("other addr", 3, 33'h0_0000_0001);
    bus_addr <= 7'h0e;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    probe("in reset", 3, 33'h0_0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("tgt_max again", off_tgt_max, 33'h0_0000_00c8);
    wrap_up();
  end
endmodule
`default_nettype wire
